// >>> core/mcel_pkg.sv
// package: register map, field layout and carriers for machine check error logging
package mcel_pkg;
    localparam int ADDR_W = 40;
    // apb byte offsets
    localparam logic [7:0] OFF_BANK0_STATUS = 8'h00;
    localparam logic [7:0] OFF_BANK1_STATUS = 8'h04;
    localparam logic [7:0] OFF_BANK1_ADDR_LO = 8'h08;
    localparam logic [7:0] OFF_BANK1_ADDR_HI = 8'h0C;
    localparam logic [7:0] OFF_BANK2_STATUS = 8'h10;
    localparam logic [7:0] OFF_BANK2_CTL = 8'h14;
    localparam logic [7:0] OFF_BANK0_CTL = 8'h18;
    localparam logic [7:0] OFF_BANK1_CTL = 8'h1C;
    localparam logic [7:0] OFF_LIC_ESR = 8'h20;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFF_BUSQ_STATUS = 8'h2C;
    // bank status field positions
    localparam int ST_VALID = 31;
    localparam int ST_OVER = 30;
    localparam int ST_UNCORRECTED_FLAG = 29;
    localparam int ST_EN = 28;
    localparam int ST_ADDRV = 26;
    localparam int ST_PCC = 25;
    localparam int ST_CODE_W = 16;
    // receive-illegal-vector flag in the interrupt controller error status
    localparam int ESR_RX_ILL_VEC = 6;
    localparam int ESR_W = 8;
    // interrupt status bits
    localparam int IRQ_BANK0 = 0;
    localparam int IRQ_BANK1 = 1;
    localparam int IRQ_BANK2 = 2;
    localparam int IRQ_LIC = 3;
    localparam int IRQ_BUSQ = 4;
    localparam int IRQ_W = 5;
    localparam logic [31:0] CTL_RESET = 32'hFFFFFFFF;
    localparam int BUSQ_DEPTH = 8;
    localparam int BUSQ_IDX_W = 3;

    // one error report from a cache, bus or interrupt source into a bank
    typedef struct packed {
        logic valid;
        logic uncorrected_flag;
        logic context_corrupt_flag;
        logic [ST_CODE_W-1:0] code;
    } mcel_err_t;

    // first-level cache parity report with its own captured address
    typedef struct packed {
        logic valid;
        logic addr_ok;
        logic xlate_done;
        logic res_conflict;
        logic [ADDR_W-1:0] addr;
    } mcel_par_t;
endpackage

// >>> core/mcel_bank.sv
// one error-logging bank: status word, optional address, overflow tracking
`timescale 1ns/1ps
module mcel_bank
    import mcel_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire mcel_err_t err_in,
    input wire logic addr_ok_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [31:0] ctl_in,
    input wire logic clr_in,
    output logic [31:0] status_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic mce_out
);
    logic held_uncorrected_flag;
    assign held_uncorrected_flag = status_out[ST_VALID] && status_out[ST_UNCORRECTED_FLAG];

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            status_out <= 32'h00000000;
        end else if (err_in.valid && held_uncorrected_flag) begin
            status_out[ST_OVER] <= 1'b1;
        end else if (err_in.valid) begin
            // still logged when reporting is disabled
            status_out <= '0;
            status_out[ST_VALID] <= 1'b1;
            status_out[ST_UNCORRECTED_FLAG] <= err_in.uncorrected_flag;
            status_out[ST_PCC] <= err_in.context_corrupt_flag;
            status_out[ST_EN] <= |ctl_in;
            status_out[ST_ADDRV] <= addr_ok_in;
            status_out[ST_OVER] <= status_out[ST_VALID];
            status_out[ST_CODE_W-1:0] <= err_in.code;
        end else if (clr_in) begin
            status_out <= 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            addr_out <= '0;
        end else if (err_in.valid && !held_uncorrected_flag && addr_ok_in) begin
            addr_out <= addr_in;
        end
    end

    // exception only for uncorrected errors with reporting enabled
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            mce_out <= 1'b0;
        end else begin
            mce_out <= err_in.valid && err_in.uncorrected_flag && (|ctl_in);
        end
    end
endmodule // mcel_bank

// >>> core/mcel_top.sv
// machine check error logging: three banks, interrupt controller errors, bus queue
// Notes on behaviour
// - bank two logs uncorrected errors with control all zero but raises no exception
// - cache parity logs the faulting data address, never a later access address
// - address-valid set only with a valid address, not on translation miss or conflict
// - a further error into a bank holding a valid uncorrected error sets overflow
// - every interrupt controller error is recorded; bit 6 marks an illegal vector
// - a snoop-deferred transaction hit by hard failure leaves the bus queue
`timescale 1ns/1ps
module mcel_top
    import mcel_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [31:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire mcel_err_t bank0_err_in,
    input wire mcel_par_t bank1_par_in,
    input wire mcel_err_t bank2_err_in,
    input wire logic [ESR_W-1:0] lic_err_in,
    input wire logic busq_alloc_in,
    input wire logic [BUSQ_IDX_W-1:0] busq_alloc_idx_in,
    input wire logic busq_snoop_defer_in,
    input wire logic [BUSQ_IDX_W-1:0] busq_defer_idx_in,
    input wire logic busq_done_in,
    input wire logic [BUSQ_IDX_W-1:0] busq_done_idx_in,
    input wire logic busq_hard_fail_in,
    input wire logic [BUSQ_IDX_W-1:0] busq_fail_idx_in,
    output logic [BUSQ_DEPTH-1:0] busq_busy_out,
    output logic busq_full_out,
    output logic machine_check_exception_out,
    output logic irq_out
);
    logic [31:0] ctl_r [3];
    logic [ESR_W-1:0] esr_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [BUSQ_DEPTH-1:0] deferred_r;
    logic [31:0] st0, st1, st2;
    logic [ADDR_W-1:0] a0, a1, a2;
    logic mce0, mce1, mce2;
    logic wr_en, rd_en;
    logic acc_first;
    logic [7:0] off;
    logic [31:0] rd_nxt;
    logic addr_hit;
    logic [IRQ_W-1:0] ev;
    logic par_ok;
    mcel_err_t par_err;

    assign off = paddr_in[7:0];
    // a write lands on the first access edge only, so a write that replaces the
    // error status cannot repeat on the answer edge and drop a flag set meanwhile
    assign acc_first = psel_in && penable_in && !pready_out;
    assign wr_en = acc_first && pwrite_in && addr_hit; // refused offsets never write
    assign rd_en = acc_first && !pwrite_in;

    // address only trusted after translation finished without conflict
    assign par_ok = bank1_par_in.addr_ok && bank1_par_in.xlate_done
        && !bank1_par_in.res_conflict;
    always_comb begin
        par_err = '0;
        par_err.valid = bank1_par_in.valid;
        par_err.uncorrected_flag = 1'b0;
        par_err.code = 16'h0001;
    end

    mcel_bank u_bank0 (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .err_in(bank0_err_in),
        .addr_ok_in(1'b0), .addr_in('0), .ctl_in(ctl_r[0]),
        .clr_in(wr_en && off == OFF_BANK0_STATUS),
        .status_out(st0), .addr_out(a0), .mce_out(mce0));
    // the address travels with the report, so a later access cannot overwrite it
    mcel_bank u_bank1 (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .err_in(par_err),
        .addr_ok_in(par_ok), .addr_in(bank1_par_in.addr), .ctl_in(ctl_r[1]),
        .clr_in(wr_en && off == OFF_BANK1_STATUS),
        .status_out(st1), .addr_out(a1), .mce_out(mce1));
    mcel_bank u_bank2 (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .err_in(bank2_err_in),
        .addr_ok_in(1'b0), .addr_in('0), .ctl_in(ctl_r[2]),
        .clr_in(wr_en && off == OFF_BANK2_STATUS),
        .status_out(st2), .addr_out(a2), .mce_out(mce2));

    // all ones after reset: every error class reports until software writes the whole word to zero
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ctl_r[0] <= CTL_RESET;
            ctl_r[1] <= CTL_RESET;
            ctl_r[2] <= CTL_RESET;
        end else if (wr_en) begin
            if (off == OFF_BANK0_CTL) ctl_r[0] <= pwdata_in;
            if (off == OFF_BANK1_CTL) ctl_r[1] <= pwdata_in;
            if (off == OFF_BANK2_CTL) ctl_r[2] <= pwdata_in;
        end
    end

    // error status: new errors OR in, so a software write never masks them
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            esr_r <= '0;
        end else if (wr_en && off == OFF_LIC_ESR) begin
            esr_r <= lic_err_in;
        end else begin
            esr_r <= esr_r | lic_err_in;
        end
    end

    // bus queue: deferred entries are retired by a hard failure
    // allocation wins so a reused slot never inherits a stale deferral
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            busq_busy_out <= '0;
            deferred_r <= '0;
        end else begin
            for (int i = 0; i < BUSQ_DEPTH; i++) begin
                if (busq_alloc_in && busq_alloc_idx_in == BUSQ_IDX_W'(i)) begin
                    busq_busy_out[i] <= 1'b1;
                    deferred_r[i] <= 1'b0;
                end else if (busq_hard_fail_in && busq_fail_idx_in == BUSQ_IDX_W'(i)
                    && deferred_r[i]) begin
                    busq_busy_out[i] <= 1'b0;
                    deferred_r[i] <= 1'b0;
                end else if (busq_done_in && busq_done_idx_in == BUSQ_IDX_W'(i)) begin
                    busq_busy_out[i] <= 1'b0;
                    deferred_r[i] <= 1'b0;
                end else if (busq_snoop_defer_in && busq_defer_idx_in == BUSQ_IDX_W'(i)
                    && busq_busy_out[i]) begin
                    deferred_r[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) busq_full_out <= 1'b0;
        else busq_full_out <= &busq_busy_out;
    end

    // second stage keeps the exception behind the logged status word
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) machine_check_exception_out <= 1'b0;
        else machine_check_exception_out <= mce0 | mce1 | mce2;
    end

    // sticky events; set beats a write-one clear in the same cycle
    always_comb begin
        ev = '0;
        ev[IRQ_BANK0] = bank0_err_in.valid;
        ev[IRQ_BANK1] = bank1_par_in.valid;
        ev[IRQ_BANK2] = bank2_err_in.valid;
        ev[IRQ_LIC] = |lic_err_in;
        ev[IRQ_BUSQ] = busq_hard_fail_in && deferred_r[busq_fail_idx_in];
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (wr_en && off == OFF_IRQ_STATUS) begin
                irq_stat_r <= (irq_stat_r & ~pwdata_in[IRQ_W-1:0]) | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
            if (wr_en && off == OFF_IRQ_MASK) irq_mask_r <= pwdata_in[IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) irq_out <= 1'b0;
        else irq_out <= |(irq_stat_r & irq_mask_r);
    end

    always_comb begin
        rd_nxt = 32'h00000000;
        addr_hit = 1'b1;
        case (off)
            OFF_BANK0_STATUS: rd_nxt = st0;
            OFF_BANK1_STATUS: rd_nxt = st1;
            OFF_BANK1_ADDR_LO: rd_nxt = a1[31:0];
            OFF_BANK1_ADDR_HI: rd_nxt = {24'h000000, a1[ADDR_W-1:32]};
            OFF_BANK2_STATUS: rd_nxt = st2;
            OFF_BANK0_CTL: rd_nxt = ctl_r[0];
            OFF_BANK1_CTL: rd_nxt = ctl_r[1];
            OFF_BANK2_CTL: rd_nxt = ctl_r[2];
            OFF_LIC_ESR: rd_nxt = {24'h000000, esr_r};
            OFF_IRQ_STATUS: rd_nxt = {27'h0000000, irq_stat_r};
            OFF_IRQ_MASK: rd_nxt = {27'h0000000, irq_mask_r};
            OFF_BUSQ_STATUS: rd_nxt = {24'h000000, busq_busy_out};
            default: addr_hit = 1'b0;
        endcase
        if (paddr_in[31:8] != 24'h000000 || paddr_in[1:0] != 2'b00) addr_hit = 1'b0;
    end

    // one wait state: pready rises in the second access cycle so outputs stay registered
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= acc_first;
            pslverr_out <= acc_first && !addr_hit;
        end
    end

    // read data stands for the answer cycle only, zero otherwise
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            prdata_out <= 32'h00000000;
        end else begin
            prdata_out <= (rd_en && addr_hit) ? rd_nxt : 32'h00000000;
        end
    end
    // unused bank addresses
    logic unused_a;
    assign unused_a = ^{a0, a2};
endmodule // mcel_top

// >>> sim/mcel_asserts.sv
// checker: port-level properties of the error logging block
`timescale 1ns/1ps
module mcel_asserts
    import mcel_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [31:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire mcel_err_t bank0_err_in,
    input wire mcel_par_t bank1_par_in,
    input wire mcel_err_t bank2_err_in,
    input wire logic [ESR_W-1:0] lic_err_in,
    input wire logic busq_alloc_in,
    input wire logic [BUSQ_IDX_W-1:0] busq_alloc_idx_in,
    input wire logic busq_snoop_defer_in,
    input wire logic [BUSQ_IDX_W-1:0] busq_defer_idx_in,
    input wire logic busq_hard_fail_in,
    input wire logic [BUSQ_IDX_W-1:0] busq_fail_idx_in,
    input wire logic [BUSQ_DEPTH-1:0] busq_busy_out,
    input wire logic machine_check_exception_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    // writes land on the first access edge; read data is judged in the answer cycle
    wire wr = psel_in && penable_in && pwrite_in && !pready_out;
    wire rd = psel_in && pready_out && !pwrite_in;
    wire [7:0] a = paddr_in[7:0];
    wire b2u = bank2_err_in.valid && bank2_err_in.uncorrected_flag;
    wire b1g = bank1_par_in.valid && bank1_par_in.addr_ok && bank1_par_in.xlate_done
        && !bank1_par_in.res_conflict;
    logic z2_r, h2_r, ov2_r, av1_r, iv_r;
    logic [31:0] a1_r;
    logic [BUSQ_DEPTH-1:0] df_r;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            z2_r <= 1'h0;
            h2_r <= 1'h0;
            ov2_r <= 1'h0;
            av1_r <= 1'h0;
            iv_r <= 1'h0;
            a1_r <= 32'h0;
            df_r <= '0;
        end else begin
            if (wr && a == OFF_BANK2_CTL) z2_r <= (pwdata_in == 32'h0);
            if (wr && a == OFF_BANK2_STATUS) h2_r <= 1'h0;
            if (wr && a == OFF_BANK2_STATUS) ov2_r <= 1'h0;
            else if (bank2_err_in.valid && h2_r) ov2_r <= 1'h1;
            if (b2u) h2_r <= 1'h1;
            if (wr && a == OFF_BANK1_STATUS) av1_r <= 1'h0;
            if (bank1_par_in.valid) av1_r <= b1g;
            if (b1g) a1_r <= bank1_par_in.addr[31:0];
            if (wr && a == OFF_LIC_ESR) iv_r <= lic_err_in[ESR_RX_ILL_VEC];
            else if (lic_err_in[ESR_RX_ILL_VEC]) iv_r <= 1'h1;
            if (busq_snoop_defer_in && busq_busy_out[busq_defer_idx_in]) begin
                df_r[busq_defer_idx_in] <= 1'h1;
            end
            if (busq_alloc_in) df_r[busq_alloc_idx_in] <= 1'h0;
        end
    end
    no_mce_a: assert property (b2u && z2_r && !bank0_err_in.valid ##1 !bank0_err_in.valid
        |-> ##1 !machine_check_exception_out)
        else $error("exception raised with bank two disabled");
    mce_cause_a: assert property ($rose(machine_check_exception_out)
        |-> $past(b2u || bank0_err_in.valid && bank0_err_in.uncorrected_flag, 2))
        else $error("exception without cause");
    fault_addr_a: assert property (rd && a == OFF_BANK1_ADDR_LO && $past(av1_r)
        |-> prdata_out == $past(a1_r)) else $error("bank one address not the faulting one");
    addr_valid_a: assert property (rd && a == OFF_BANK1_STATUS
        |-> prdata_out[ST_ADDRV] == $past(av1_r)) else $error("bank one address-valid wrong");
    over_flag_a: assert property (rd && a == OFF_BANK2_STATUS && $past(ov2_r)
        |-> prdata_out[ST_OVER]) else $error("overflow not set");
    ill_vec_a: assert property (rd && a == OFF_LIC_ESR
        |-> prdata_out[ESR_RX_ILL_VEC] == $past(iv_r)) else $error("illegal vector flag wrong");
    busq_free_a: assert property (busq_hard_fail_in && df_r[busq_fail_idx_in]
        && !(busq_alloc_in && busq_alloc_idx_in == busq_fail_idx_in)
        |=> !busq_busy_out[$past(busq_fail_idx_in)]) else $error("failed entry still queued");
endmodule // mcel_asserts

// >>> sim/mcel_top_tb_top.sv
// testbench: drives registers, error sources and bus queue of the logging block
`timescale 1ns/1ps
module mcel_top_tb_top;
    import mcel_pkg::*;
    logic ref_clk_in = 1'h0;
    logic srst_in = 1'h1;
    logic [31:0] paddr_in = 32'h0, pwdata_in = 32'h0, prdata_out, q;
    logic psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0, e, m;
    mcel_err_t bank0_err_in = '0, bank2_err_in = '0;
    mcel_par_t bank1_par_in = '0;
    logic [ESR_W-1:0] lic_err_in = '0;
    logic busq_alloc_in = 1'h0, busq_snoop_defer_in = 1'h0, busq_done_in = 1'h0;
    logic busq_hard_fail_in = 1'h0;
    logic [BUSQ_IDX_W-1:0] busq_alloc_idx_in = '0, busq_defer_idx_in = '0;
    logic [BUSQ_IDX_W-1:0] busq_done_idx_in = '0, busq_fail_idx_in = '0;
    logic pready_out, pslverr_out, busq_full_out, machine_check_exception_out, irq_out;
    logic [BUSQ_DEPTH-1:0] busq_busy_out;
    int n_fail = 0, num_checks = 0, cyc = 0;
    mcel_top mcel_top_inst (.*);
    always #4 ref_clk_in = ~ref_clk_in;
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    // l is an interrupt controller error presented on the write-landing edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [7:0] l);
        @(posedge ref_clk_in);
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= {24'h0, a};
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'h1;
        lic_err_in <= l;
        do begin
            @(posedge ref_clk_in);
            lic_err_in <= 8'h0;
        end while (pready_out !== 1'h1);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    task b2(input mcel_err_t v);
        @(posedge ref_clk_in);
        bank2_err_in <= v;
        m = 1'h0;
        repeat (4) begin
            @(posedge ref_clk_in);
            bank2_err_in <= '0;
            m = m | machine_check_exception_out;
        end
    endtask
    task par(input mcel_par_t v);
        @(posedge ref_clk_in);
        bank1_par_in <= v;
        @(posedge ref_clk_in);
        bank1_par_in <= '0;
    endtask
    task t_bank2;
        apb(1'h0, OFF_BANK0_CTL, 32'h0, 8'h0);
        chk(q, CTL_RESET);
        apb(1'h1, OFF_BANK2_CTL, 32'h0, 8'h0);
        b2({1'h1, 1'h1, 1'h0, 16'h0123});
        chk({31'h0, m}, 32'h0);
        apb(1'h0, OFF_BANK2_STATUS, 32'h0, 8'h0);
        chk(q, 32'hA0000123);
        apb(1'h1, OFF_BANK2_CTL, 32'hFFFFFFFF, 8'h0);
        apb(1'h1, OFF_BANK2_STATUS, 32'h0, 8'h0);
        b2({1'h1, 1'h1, 1'h0, 16'h0456});
        chk({31'h0, m}, 32'h1);
        b2({1'h1, 1'h0, 1'h0, 16'h0789});
        apb(1'h0, OFF_BANK2_STATUS, 32'h0, 8'h0);
        chk(q, 32'hF0000456);
        @(posedge ref_clk_in);
        bank0_err_in <= {1'h1, 1'h1, 1'h1, 16'h0042};
        @(posedge ref_clk_in);
        bank0_err_in <= '0;
        apb(1'h0, OFF_BANK0_STATUS, 32'h0, 8'h0);
        chk(q, 32'hB2000042);
    endtask
    task t_bank1;
        par({1'h1, 1'h1, 1'h1, 1'h0, 40'h123456789C});
        apb(1'h0, OFF_BANK1_STATUS, 32'h0, 8'h0);
        chk(q, 32'h94000001);
        apb(1'h0, OFF_BANK1_ADDR_LO, 32'h0, 8'h0);
        chk(q, 32'h3456789C);
        par({1'h1, 1'h1, 1'h0, 1'h0, 40'hFF00000000});
        par({1'h1, 1'h1, 1'h1, 1'h1, 40'hEE00000000});
        apb(1'h0, OFF_BANK1_STATUS, 32'h0, 8'h0);
        chk(q, 32'hD0000001);
        apb(1'h0, OFF_BANK1_ADDR_LO, 32'h0, 8'h0);
        chk(q, 32'h3456789C);
        apb(1'h0, OFF_BANK1_ADDR_HI, 32'h0, 8'h0);
        chk(q, 32'h12);
    endtask
    task t_lic;
        @(posedge ref_clk_in);
        lic_err_in <= 8'h40;
        @(posedge ref_clk_in);
        lic_err_in <= 8'h01;
        @(posedge ref_clk_in);
        lic_err_in <= 8'h0;
        apb(1'h0, OFF_LIC_ESR, 32'h0, 8'h0);
        chk(q, 32'h41);
        apb(1'h1, OFF_LIC_ESR, 32'h0, 8'h40);
        apb(1'h0, OFF_LIC_ESR, 32'h0, 8'h0);
        chk(q, 32'h40);
    endtask
    task t_busq;
        @(posedge ref_clk_in);
        busq_alloc_in <= 1'h1;
        busq_alloc_idx_in <= 3'h3;
        @(posedge ref_clk_in);
        busq_alloc_in <= 1'h0;
        busq_snoop_defer_in <= 1'h1;
        busq_defer_idx_in <= 3'h3;
        @(posedge ref_clk_in);
        busq_snoop_defer_in <= 1'h0;
        @(posedge ref_clk_in);
        chk({24'h0, busq_busy_out}, 32'h08);
        busq_hard_fail_in <= 1'h1;
        busq_fail_idx_in <= 3'h3;
        @(posedge ref_clk_in);
        busq_hard_fail_in <= 1'h0;
        @(posedge ref_clk_in);
        chk({24'h0, busq_busy_out}, 32'h0);
        apb(1'h0, OFF_IRQ_STATUS, 32'h0, 8'h0);
        chk(q, 32'h1F);
        apb(1'h1, OFF_IRQ_MASK, 32'h10, 8'h0);
        @(posedge ref_clk_in);
        chk({31'h0, irq_out}, 32'h1);
        apb(1'h1, OFF_IRQ_STATUS, 32'h10, 8'h0);
        @(posedge ref_clk_in);
        chk({31'h0, irq_out}, 32'h0);
        apb(1'h0, 8'h30, 32'h0, 8'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        for (int i = 0; i < BUSQ_DEPTH; i++) begin
            @(posedge ref_clk_in);
            busq_alloc_in <= 1'h1;
            busq_alloc_idx_in <= BUSQ_IDX_W'(i);
        end
        @(posedge ref_clk_in);
        busq_alloc_in <= 1'h0;
        repeat (2) @(posedge ref_clk_in);
        chk({31'h0, busq_full_out}, 32'h1);
        busq_done_in <= 1'h1;
        busq_done_idx_in <= 3'h0;
        @(posedge ref_clk_in);
        busq_done_in <= 1'h0;
        repeat (2) @(posedge ref_clk_in);
        chk({31'h0, busq_full_out}, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge ref_clk_in);
        srst_in <= 1'h0;
        t_bank2();
        t_bank1();
        t_lic();
        t_busq();
        close_out();
    end
endmodule // mcel_top_tb_top
bind mcel_top mcel_asserts mcel_asserts_inst (.*);
